/* File: verilog/glue_pkg.sv */
// Constants, types and register map of the memory chip enable glue.
`default_nettype none
package glue_pkg;
    // System clock rate of this block.
    localparam int CLK_HZ = 100_000_000;
    // Least address setup the FRAM needs before its enable falls.
    localparam int NV_SETUP_NS = 30;
    localparam int NV_SETUP_CYC =
        (NV_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Wait states the processor must use for the non-volatile space.
    localparam int NV_MIN_WAIT_STATES = 3;
    localparam int NV_RESET_WAIT_STATES = 30;
    // Memory map.
    localparam logic [31:0] NV_BANK0_BASE = 32'h0000_0000;
    localparam logic [31:0] NV_BANK1_BASE = 32'h1000_0000;
    localparam logic [31:0] NV_BANK_BYTES = 32'h0020_0000;
    localparam logic [31:0] SRAM_BYTES    = 32'h0080_0000;
    localparam int NV_BANKS     = 2;
    localparam int SRAM_DIES    = 4;
    localparam int DIE_ADDR_W   = 2;
    localparam int CPU_DATA_W   = 32;
    localparam int CHECK_W      = 8;
    localparam int SRAM_W       = CPU_DATA_W + CHECK_W;
    localparam int CHECK_LSB    = 32;
    // Register bus.
    localparam int WB_ADR_W = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_SETUP_LSB = 0;
    localparam int CTRL_SETUP_W   = 4;
    localparam int CTRL_SRAM_EN   = 8;
    localparam logic [31:0] CTRL_RESET =
        (32'(NV_SETUP_CYC) << CTRL_SETUP_LSB) | (32'h1 << CTRL_SRAM_EN);
    localparam int STAT_NV_LSB    = 0;
    localparam int STAT_DIE_LSB   = 2;
    localparam int STAT_SLEEP_LSB = 6;
    localparam logic [CTRL_SETUP_W-1:0] SETUP_MIN = 4'h1;

    typedef enum logic [2:0] {
        NV_IDLE   = 3'b001,
        NV_SETUP  = 3'b010,
        NV_ACTIVE = 3'b100
    } nv_state_t;

    // Processor-side pins, all active low where named _n.
    typedef struct packed {
        logic [NV_BANKS-1:0]   nv_bank_select_n;
        logic                  ram_bank_select_n;
        logic [DIE_ADDR_W-1:0] die_addr;
        logic [NV_BANKS-1:0]   sleep_gpio;
        logic [NV_BANKS-1:0]   sleep_gpio_oe_n;
    } pin_in_t;
endpackage : glue_pkg
`default_nettype wire

/* File: verilog/memory_chip_enable_glue.sv */
// Chip enable glue between the processor memory controller and FRAM/SRAM.
//
// Added by the designer: the address map and the Wishbone register port.
`default_nettype none
module memory_chip_enable_glue (
    input  wire logic                             clk_sys_in,
    input  wire logic                             rst_in,
    input  wire logic [glue_pkg::WB_ADR_W-1:0]    wb_adr_in,
    input  wire logic [31:0]                      wb_dat_in,
    input  wire logic [3:0]                       wb_sel_in,
    input  wire logic                             wb_we_in,
    input  wire logic                             wb_cyc_in,
    input  wire logic                             wb_stb_in,
    output logic [31:0]                           wb_dat_out,
    output logic                                  wb_ack_out,
    input  wire glue_pkg::pin_in_t                pins_in,
    input  wire logic [glue_pkg::CPU_DATA_W-1:0]  cpu_wdata_in,
    input  wire logic [glue_pkg::CHECK_W-1:0]     cpu_check_in,
    input  wire logic [glue_pkg::SRAM_W-1:0]      sram_rdata_in,
    output logic [glue_pkg::SRAM_W-1:0]           sram_wdata_out,
    output logic [glue_pkg::CPU_DATA_W-1:0]       cpu_rdata_out,
    output logic [glue_pkg::CHECK_W-1:0]          cpu_check_out,
    output logic [glue_pkg::NV_BANKS-1:0]         nv_ce_n_out,
    output logic [glue_pkg::SRAM_DIES-1:0]        sram_ce_n_out,
    output logic                                  nv_bank0_sleep_n_out,
    output logic                                  nv_bank1_sleep_n_out
);
    import glue_pkg::*;

    // Pin synchronisers; the first stage feeds only the second.
    pin_in_t                pins_meta_q;
    pin_in_t                pins_q;
    logic [CPU_DATA_W-1:0]  wdata_meta_q;
    logic [CPU_DATA_W-1:0]  wdata_q;
    logic [CHECK_W-1:0]     check_meta_q;
    logic [CHECK_W-1:0]     check_q;
    logic [SRAM_W-1:0]      rdata_meta_q;
    logic [SRAM_W-1:0]      rdata_q;

    // The only reset input is power-on; processor resets never reach here.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            pins_meta_q <= '1;
            pins_q      <= '1;
        end
        else
        begin
            pins_meta_q <= pins_in;
            pins_q      <= pins_meta_q;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        wdata_meta_q <= cpu_wdata_in;
        wdata_q      <= wdata_meta_q;
        check_meta_q <= cpu_check_in;
        check_q      <= check_meta_q;
        rdata_meta_q <= sram_rdata_in;
        rdata_q      <= rdata_meta_q;
    end

    // Control register.
    logic [31:0]             ctrl_q;
    logic [CTRL_SETUP_W-1:0] setup_cyc;
    logic                    sram_en;

    assign setup_cyc = (ctrl_q[CTRL_SETUP_LSB +: CTRL_SETUP_W] < SETUP_MIN)
                     ? SETUP_MIN
                     : ctrl_q[CTRL_SETUP_LSB +: CTRL_SETUP_W];
    assign sram_en   = ctrl_q[CTRL_SRAM_EN];

    // FRAM enable retiming, one machine per bank; the bank map itself
    // lives in the processor's decoder, each select owning one 2 MB bank.
    wire logic [NV_BANKS-1:0] nv_ce_n;

    // Each bank keeps its own state, so no vector has two writers.
    genvar b;
    generate
        for (b = 0; b < NV_BANKS; b++)
        begin : g_nv
            nv_state_t               state_q;
            nv_state_t               state_d;
            logic [CTRL_SETUP_W-1:0] cnt_q;
            logic                    ce_n_q;
            logic                    sel;

            assign sel        = !pins_q.nv_bank_select_n[b];
            assign nv_ce_n[b] = ce_n_q;

            always_comb
            begin
                state_d = state_q;
                unique case (state_q)
                    NV_IDLE:
                        if (sel)
                            state_d = NV_SETUP;
                    NV_SETUP:
                        if (!sel)
                            state_d = NV_IDLE;
                        else if (cnt_q >= setup_cyc - SETUP_MIN)
                            state_d = NV_ACTIVE;
                    NV_ACTIVE:
                        if (!sel)
                            state_d = NV_IDLE;
                    default:
                        state_d = NV_IDLE;
                endcase
            end

            always_ff @(posedge clk_sys_in)
            begin
                if (rst_in)
                begin
                    state_q <= NV_IDLE;
                    ce_n_q  <= 1'b1;
                    cnt_q   <= '0;
                end
                else
                begin
                    state_q <= state_d;
                    ce_n_q  <= (state_d != NV_ACTIVE);
                    if (state_q == NV_SETUP)
                        cnt_q <= cnt_q + 1'b1;
                    else
                        cnt_q <= '0;
                end
            end
        end
    endgenerate

    assign nv_ce_n_out = nv_ce_n;

    // SRAM die decode; registered so each enable is glitch free.
    logic [SRAM_DIES-1:0] sram_ce_n_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            sram_ce_n_q <= '1;
        else if (!pins_q.ram_bank_select_n && sram_en)
            sram_ce_n_q <= ~(SRAM_DIES'(1) << pins_q.die_addr);
        else
            sram_ce_n_q <= '1;
    end

    assign sram_ce_n_out = sram_ce_n_q;

    // Data and check bits share one 40-bit SRAM word, three register stages from pin to output.
    logic [SRAM_W-1:0]     sram_wdata_q;
    logic [CPU_DATA_W-1:0] cpu_rdata_q;
    logic [CHECK_W-1:0]    cpu_check_q;

    always_ff @(posedge clk_sys_in)
    begin
        sram_wdata_q <= {check_q, wdata_q};
        cpu_rdata_q  <= rdata_q[CPU_DATA_W-1:0];
        cpu_check_q  <= rdata_q[CHECK_LSB +: CHECK_W];
    end

    assign sram_wdata_out = sram_wdata_q;
    assign cpu_rdata_out  = cpu_rdata_q;
    assign cpu_check_out  = cpu_check_q;

    // Sleep lines: a GPIO left as input floats, so it reads as awake.
    logic [NV_BANKS-1:0] sleep_n_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            sleep_n_q <= '1;
        else
            for (int i = 0; i < NV_BANKS; i++)
                sleep_n_q[i] <= pins_q.sleep_gpio_oe_n[i]
                              | pins_q.sleep_gpio[i];
    end

    assign nv_bank0_sleep_n_out = sleep_n_q[0];
    assign nv_bank1_sleep_n_out = sleep_n_q[1];

    // Wishbone slave: one cycle to answer, unmapped reads return zero.
    logic        ack_q;
    logic [31:0] dat_q;
    logic        req;

    assign req = wb_cyc_in && wb_stb_in && !ack_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            ctrl_q <= CTRL_RESET;
        else if (req && wb_we_in && wb_adr_in == REG_CTRL)
            for (int i = 0; i < 4; i++)
                if (wb_sel_in[i])
                    ctrl_q[i*8 +: 8] <= wb_dat_in[i*8 +: 8];
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            dat_q <= '0;
        else if (req && !wb_we_in)
        begin
            dat_q <= '0;
            if (wb_adr_in == REG_CTRL)
                dat_q <= ctrl_q;
            else if (wb_adr_in == REG_STATUS)
            begin
                dat_q[STAT_NV_LSB +: NV_BANKS]     <= ~nv_ce_n;
                dat_q[STAT_DIE_LSB +: SRAM_DIES]   <= ~sram_ce_n_q;
                dat_q[STAT_SLEEP_LSB +: NV_BANKS]  <= sleep_n_q;
            end
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = dat_q;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    die_onehot_a: assert property ($onehot0(~sram_ce_n_out))
        else $error("More than one SRAM die enabled.");
    die_gate_a: assert property (
        !(&sram_ce_n_out) |-> !$past(pins_q.ram_bank_select_n))
        else $error("SRAM die enabled without RAM select.");
    die_map_a: assert property (
        (!pins_q.ram_bank_select_n && sram_en)
        |=> !sram_ce_n_out[$past(pins_q.die_addr)])
        else $error("Wrong SRAM die enabled.");
    nv_release_a: assert property (
        pins_q.nv_bank_select_n[0] |=> nv_ce_n_out[0])
        else $error("FRAM enable outlived its bank select.");
    nv_setup_a: assert property (
        $fell(nv_ce_n_out[1])
        |-> $past(!pins_q.nv_bank_select_n[1], 2)
            && $past(!pins_q.nv_bank_select_n[1]))
        else $error("FRAM enable fell without setup.");
    sleep_pull_a: assert property (
        pins_q.sleep_gpio_oe_n[0] |=> nv_bank0_sleep_n_out)
        else $error("Sleep line not pulled high.");
    sleep_drive_a: assert property (
        !pins_q.sleep_gpio_oe_n[1]
        |=> nv_bank1_sleep_n_out == $past(pins_q.sleep_gpio[1]))
        else $error("Sleep line does not follow its GPIO.");
    sleep_reset_a: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        rst_in |=> nv_bank0_sleep_n_out && nv_bank1_sleep_n_out)
        else $error("Sleep lines low after reset.");
    word_map_a: assert property (
        ##1 sram_wdata_out == {$past(check_q), $past(wdata_q)})
        else $error("SRAM word lanes misplaced.");
    check_map_a: assert property (
        ##1 cpu_check_out == $past(rdata_q[SRAM_W-1:CHECK_LSB]))
        else $error("Check bits not on SRAM bits 39 to 32.");
    nv_early_a: assert property (
        $fell(nv_ce_n_out[0])
        |-> $past(!pins_q.nv_bank_select_n[0], 2)
            && $past(!pins_q.nv_bank_select_n[0]))
        else $error("FRAM bank 0 enable fell without setup.");
    nv_hold_a: assert property (
        pins_q.nv_bank_select_n[1] |=> nv_ce_n_out[1])
        else $error("FRAM bank 1 enable outlived its bank select.");
    data_map_a: assert property (
        ##1 cpu_rdata_out == $past(rdata_q[CPU_DATA_W-1:0]))
        else $error("Data bits not on SRAM bits 31 to 0.");
    die_idle_a: assert property (
        pins_q.ram_bank_select_n |=> &sram_ce_n_out)
        else $error("SRAM die enabled while RAM select is high.");

    nv0_access_c: cover property ($fell(nv_ce_n_out[0]));
    nv1_access_c: cover property ($fell(nv_ce_n_out[1]));
    die3_access_c: cover property (!sram_ce_n_out[3]);
    ctrl_write_c: cover property (req && wb_we_in);
    sleep_low_c: cover property (!nv_bank0_sleep_n_out);
endmodule : memory_chip_enable_glue
`default_nettype wire

/* File: verif/cpu_mem_model.sv */
// Processor memory controller and SRAM model driving the glue's pins.
`default_nettype none
module cpu_mem_model
    import glue_pkg::*;
(
    input  wire logic                   clk_sys_in,
    output glue_pkg::pin_in_t           pins_out,
    output logic [glue_pkg::SRAM_W-1:0] sram_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // GPIOs start as inputs, so the pull-ups keep both banks awake.
    initial pins_out = '{2'b11, 1'b1, 2'h0, 2'h0, 2'b11};
    initial sram_rdata_out = '0;
    // The bank follows from the address; the hold stands for wait states.
    task automatic nv_access(input logic [31:0] addr, input int hold);
        int b;
        b = (addr >= NV_BANK1_BASE) ? 1 : 0;
        @(posedge clk_sys_in);
        pins_out.nv_bank_select_n[b] <= 1'b0;
        repeat (hold) @(posedge clk_sys_in);
        pins_out.nv_bank_select_n[b] <= 1'b1;
    endtask : nv_access
    task automatic ram_access(input logic [1:0] die,
                              input logic [SRAM_W-1:0] d, input int hold);
        @(posedge clk_sys_in);
        pins_out.ram_bank_select_n <= 1'b0;
        pins_out.die_addr <= die;
        sram_rdata_out <= d;
        repeat (hold) @(posedge clk_sys_in);
        pins_out.ram_bank_select_n <= 1'b1;
        // A released bus must not keep showing the last word.
        sram_rdata_out <= ~d;
    endtask : ram_access
    task automatic set_gpio(input logic oe_n, input logic [1:0] g);
        @(posedge clk_sys_in);
        pins_out.sleep_gpio_oe_n <= {2{oe_n}};
        pins_out.sleep_gpio <= g;
    endtask : set_gpio
endmodule : cpu_mem_model
`default_nettype wire

/* File: verif/memory_chip_enable_glue_test.sv */
// Self-checking bench for the memory chip enable glue.
`default_nettype none
module memory_chip_enable_glue_test;
    timeunit 1ns;
    timeprecision 1ps;
    import glue_pkg::*;
    logic              clk_sys_in, rst_in, wb_we, wb_cyc, wb_stb;
    logic              wb_ack_out, sl0, sl1;
    logic [7:0]        wb_adr;
    logic [31:0]       wb_dat, wb_dat_out;
    logic [3:0]        wb_sel, sram_ce_n, e4;
    logic [31:0]       cpu_wdata, cpu_rdata;
    logic [7:0]        cpu_check, cpu_check_out;
    logic [39:0]       sram_rdata, sram_wdata, w;
    logic [1:0]        nv_ce_n;
    pin_in_t           pins;
    int                errors, cmp_count, lat;
    logic [31:0]       expq[$];
    memory_chip_enable_glue dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .wb_adr_in(wb_adr), .wb_dat_in(wb_dat), .wb_sel_in(wb_sel),
        .wb_we_in(wb_we), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pins_in(pins),
        .cpu_wdata_in(cpu_wdata), .cpu_check_in(cpu_check),
        .sram_rdata_in(sram_rdata), .sram_wdata_out(sram_wdata),
        .cpu_rdata_out(cpu_rdata), .cpu_check_out(cpu_check_out),
        .nv_ce_n_out(nv_ce_n), .sram_ce_n_out(sram_ce_n),
        .nv_bank0_sleep_n_out(sl0), .nv_bank1_sleep_n_out(sl1));
    cpu_mem_model mdl (.clk_sys_in(clk_sys_in), .pins_out(pins),
        .sram_rdata_out(sram_rdata));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string nm, input logic [39:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // Holds the request until ack is sampled high, then drops it.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys_in);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, we, a, d, s};
        // Only the watchdog ends a wait for an answer that never comes.
        do
            @(posedge clk_sys_in);
        while (wb_ack_out !== 1'b1);
        {wb_cyc, wb_stb} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask : rd
    always @(posedge clk_sys_in)
        if (wb_ack_out === 1'b1 && !wb_we && expq.size() > 0)
            chk("wb_dat_out", wb_dat_out, expq.pop_front());
    // Select low at c0 reaches the machine at c3; enable falls at c3+setup.
    task automatic nv_chk(input int b, input int lat, input int hold);
        @(posedge clk_sys_in);
        repeat (lat - 1) @(posedge clk_sys_in);
        #1 chk("nv_ce_n early", nv_ce_n[b], 1'b1);
        @(posedge clk_sys_in);
        #1 chk("nv_ce_n", nv_ce_n, b ? 2'h1 : 2'h2);
        repeat (hold + 2 - lat) @(posedge clk_sys_in);
        #1 chk("nv_ce_n held", nv_ce_n[b], 1'b0);
        @(posedge clk_sys_in);
        #1 chk("nv_ce_n end", nv_ce_n[b], 1'b1);
    endtask : nv_chk
    task automatic sram_test(input int d, input logic [3:0] e);
        w = 40'({$urandom(), $urandom()});
        fork
            mdl.ram_access(2'(d), w, 5);
            begin
                @(posedge clk_sys_in);
                cpu_wdata <= ~w[31:0];
                cpu_check <= ~w[39:32];
                repeat (3) @(posedge clk_sys_in);
                #1 chk("sram_ce_n", sram_ce_n, e);
                chk("cpu_rdata", cpu_rdata, w[31:0]);
                chk("cpu_check", cpu_check_out, w[39:32]);
                chk("sram_wdata", sram_wdata, ~w);
            end
        join
        repeat (4) @(posedge clk_sys_in);
        #1 chk("sram_ce_n idle", sram_ce_n, 4'hF);
    endtask : sram_test
    initial
    begin
        void'($urandom(32'hD8692532));
        {wb_we, wb_cyc, wb_stb, wb_adr, wb_dat, wb_sel} = '0;
        cpu_wdata = '0;
        cpu_check = '0;
        rst_in = 1'b1;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1 chk("ce idle", {nv_ce_n, sram_ce_n}, 6'h3F);
        chk("sleep reset", {sl1, sl0}, 2'b11);
        rd(REG_CTRL, 32'h0000_0103);
        rd(REG_STATUS, 32'h0000_00C0);
        rd(8'h08, 32'h0);
        wb(1'b1, REG_STATUS, $urandom(), 4'hF);
        rd(REG_STATUS, 32'h0000_00C0);
        wb(1'b1, REG_CTRL, {24'($urandom()), 8'h05}, 4'h1);
        rd(REG_CTRL, 32'h0000_0105);
        $display("test registers done");
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 2; b++)
            begin
                wb(1'b1, REG_CTRL, 32'h100 | (s * s), 4'hF);
                lat = 3 + ((s == 0) ? 1 : s * s);
                fork
                    mdl.nv_access(b ? NV_BANK1_BASE : NV_BANK0_BASE, lat + 2);
                    nv_chk(b, lat, lat + 2);
                join
            end
        wb(1'b1, REG_CTRL, 32'h0000_0103, 4'hF);
        // Two cycles are fewer than the enable needs, so none may appear.
        fork
            mdl.nv_access(NV_BANK0_BASE, 2);
            repeat (12)
            begin
                @(posedge clk_sys_in);
                #1 chk("nv_ce_n abort", nv_ce_n, 2'b11);
            end
        join
        $display("test fram enables done");
        for (int d = 0; d < 4; d++)
            sram_test(d, 4'hF ^ (4'h1 << d));
        wb(1'b1, REG_CTRL, 32'h0000_0003, 4'hF);
        sram_test(2, 4'hF);
        $display("test sram done");
        for (int i = 0; i < 9; i++)
        begin
            e4[1:0] = {2{i[2] | i[3]}} | i[1:0];
            fork
                mdl.set_gpio(i[2] | i[3], i[1:0]);
                begin
                    repeat (4) @(posedge clk_sys_in);
                    #1 chk("sleep", {sl1, sl0}, e4[1:0]);
                end
            join
        end
        $display("test sleep done");
        conclude();
    end
    initial
    begin
        #100us;
        errors++;
        conclude();
    end
endmodule : memory_chip_enable_glue_test
`default_nettype wire
